// >>> verilog/inl_pkg.sv
// Overview of operation
// - operational device shows module green steady
// - unconfigured device flashes module green 1 Hz
// - self-test module green, red, then hold green
// - module test sequence finishes before network sequence
// - network test green, red, then dark hold
// - recoverable fault blinks module red 1 Hz
// - unrecoverable fault shows module red steady
// - ip plus connection, no timeout: network green
// - ip without connections flashes network green 1 Hz
// - exclusive owner timeout blinks network red 1 Hz
// - timeout pattern holds until all reestablished
// - duplicate ip shows network red steady
// - no ip address keeps network indicator dark
// - link indicator follows each channel link
// - activity indicator flickers only while frames move
// - 1 Hz patterns 500 ms lit, 500 dark
// - heavy traffic flickers 50 ms lit, 50 dark
// - light traffic flicker follows individual frames
package inl_pkg;
    localparam int CLK_MHZ = 50;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
    localparam int TICK_W = 16;
    localparam int MS_W = 10;
    localparam logic [MS_W-1:0] SELFTEST_STEP_MS = 10'd250;
    localparam logic [MS_W-1:0] BLINK_HALF_MS = 10'd500;
    localparam logic [MS_W-1:0] BLINK_PERIOD_MS = 10'd1000;
    localparam logic [MS_W-1:0] FLICK_HALF_MS = 10'd50;
    localparam logic [MS_W-1:0] FLICK_PERIOD_MS = 10'd100;
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] MOD_CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] NET_CTRL_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] LED_STAT_OFS = 12'h008;
    localparam int MOD_SELFTEST_BIT = 0;
    localparam int MOD_CONFIGURED_BIT = 1;
    localparam int MOD_RECOV_BIT = 2;
    localparam int MOD_UNREC_BIT = 3;
    localparam int NET_IP_BIT = 0;
    localparam int NET_CONN_BIT = 1;
    localparam int NET_TMO_BIT = 2;
    localparam int NET_DUP_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
    typedef struct packed {
        logic red;
        logic green;
    } inl_duo_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } inl_apb_req_t;
    typedef enum {MM_SELF, MM_UNREC, MM_RECOV, MM_STBY, MM_OK} inl_mod_mode_t;
    typedef enum {NM_SELF, NM_OFF, NM_DUP, NM_TMO, NM_CONN, NM_IDLE} inl_net_mode_t;
    typedef enum {ST_IDLE, ST_MS_G, ST_MS_R, ST_NS_G, ST_NS_R, ST_HOLD} inl_st_t;
endpackage : inl_pkg

// >>> verilog/inl_status_led.sv
`timescale 1ns/10ps
`default_nettype none
module inl_status_led #(
    parameter int TICK_CYCLES = inl_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // apb slave
    input wire inl_pkg::inl_apb_req_t apb_req_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    // ethernet channel pins
    input wire logic [inl_pkg::NUM_CH-1:0] link_i,
    input wire logic [inl_pkg::NUM_CH-1:0] frame_i,
    // indicators
    output inl_pkg::inl_duo_t module_health_indicator_o,
    output inl_pkg::inl_duo_t network_health_indicator_o,
    output logic [inl_pkg::NUM_CH-1:0] link_indicator_o,
    output logic [inl_pkg::NUM_CH-1:0] traffic_indicator_o
);
    import inl_pkg::*;

    localparam inl_duo_t DUO_OFF = 2'b00;
    localparam inl_duo_t DUO_GREEN = 2'b01;
    localparam inl_duo_t DUO_RED = 2'b10;

    function automatic logic [MS_W-1:0] phase_step(input logic [MS_W-1:0] ph,
                                                   input logic [MS_W-1:0] period,
                                                   input logic tick);
        phase_step = ph;
        if (tick) begin
            phase_step = (ph == period - 10'd1) ? '0 : ph + 10'd1;
        end
    endfunction : phase_step

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] ofs);
        addr_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : addr_hit

    // register bus
    logic [CTRL_W-1:0] mod_ctrl_ff;
    logic [CTRL_W-1:0] net_ctrl_ff;
    logic [31:0] prdata_ff;
    logic apb_setup;
    logic apb_wr;
    logic mapped;
    logic [31:0] led_stat;

    assign apb_setup = apb_req_i.psel && !apb_req_i.penable;
    assign apb_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
    assign mapped = addr_hit(apb_req_i.paddr, MOD_CTRL_OFS)
                 || addr_hit(apb_req_i.paddr, NET_CTRL_OFS)
                 || addr_hit(apb_req_i.paddr, LED_STAT_OFS);
    assign pready_o = 1'b1;
    assign pslverr_o = apb_req_i.psel && apb_req_i.penable && !mapped;
    assign prdata_o = prdata_ff;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mod_ctrl_ff <= CTRL_RESET;
            net_ctrl_ff <= CTRL_RESET;
        end else if (apb_wr) begin
            if (addr_hit(apb_req_i.paddr, MOD_CTRL_OFS)) begin
                mod_ctrl_ff <= apb_req_i.pwdata[CTRL_W-1:0];
            end
            if (addr_hit(apb_req_i.paddr, NET_CTRL_OFS)) begin
                net_ctrl_ff <= apb_req_i.pwdata[CTRL_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_ff <= '0;
        end else if (apb_setup && !apb_req_i.pwrite) begin
            if (addr_hit(apb_req_i.paddr, MOD_CTRL_OFS)) begin
                prdata_ff <= {28'h0000000, mod_ctrl_ff};
            end else if (addr_hit(apb_req_i.paddr, NET_CTRL_OFS)) begin
                prdata_ff <= {28'h0000000, net_ctrl_ff};
            end else if (addr_hit(apb_req_i.paddr, LED_STAT_OFS)) begin
                prdata_ff <= led_stat;
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // millisecond prescaler
    logic [TICK_W-1:0] tick_cnt_ff;
    logic ms_tick;
    assign ms_tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= ms_tick ? '0 : tick_cnt_ff + 16'h0001;
        end
    end

    // pin synchronisers
    logic [NUM_CH-1:0] link_s1_ff, link_s2_ff, frame_s1_ff, frame_s2_ff, frame_s3_ff;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            link_s1_ff <= '0;
            link_s2_ff <= '0;
            frame_s1_ff <= '0;
            frame_s2_ff <= '0;
            frame_s3_ff <= '0;
        end else begin
            link_s1_ff <= link_i;
            link_s2_ff <= link_s1_ff;
            frame_s1_ff <= frame_i;
            frame_s2_ff <= frame_s1_ff;
            frame_s3_ff <= frame_s2_ff;
        end
    end

    // self-test sequencer
    inl_st_t st_ff;
    logic [MS_W-1:0] st_ms_ff;
    logic st_step_done;
    logic selftest;
    assign selftest = mod_ctrl_ff[MOD_SELFTEST_BIT];
    assign st_step_done = ms_tick && (st_ms_ff == SELFTEST_STEP_MS - 10'd1);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_ff <= ST_IDLE;
            st_ms_ff <= '0;
        end else if (!selftest) begin
            st_ff <= ST_IDLE;
            st_ms_ff <= '0;
        end else begin
            st_ms_ff <= (st_step_done || st_ff == ST_IDLE) ? '0
                      : phase_step(st_ms_ff, SELFTEST_STEP_MS, ms_tick);
            case (st_ff)
                ST_IDLE: st_ff <= ST_MS_G;
                ST_MS_G: if (st_step_done) st_ff <= ST_MS_R;
                ST_MS_R: if (st_step_done) st_ff <= ST_NS_G;
                ST_NS_G: if (st_step_done) st_ff <= ST_NS_R;
                ST_NS_R: if (st_step_done) st_ff <= ST_HOLD;
                ST_HOLD: st_ff <= ST_HOLD;
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // mode selection
    inl_mod_mode_t mod_mode_ff, nxt_mod_mode;
    inl_net_mode_t net_mode_ff, nxt_net_mode;
    logic [MS_W-1:0] mod_ph_ff, net_ph_ff;

    always_comb begin
        if (selftest) begin
            nxt_mod_mode = MM_SELF;
        end else if (mod_ctrl_ff[MOD_UNREC_BIT]) begin
            nxt_mod_mode = MM_UNREC;
        end else if (mod_ctrl_ff[MOD_RECOV_BIT]) begin
            nxt_mod_mode = MM_RECOV;
        end else if (!mod_ctrl_ff[MOD_CONFIGURED_BIT]) begin
            nxt_mod_mode = MM_STBY;
        end else begin
            nxt_mod_mode = MM_OK;
        end
    end

    always_comb begin
        if (selftest) begin
            nxt_net_mode = NM_SELF;
        end else if (!net_ctrl_ff[NET_IP_BIT]) begin
            nxt_net_mode = NM_OFF;
        end else if (net_ctrl_ff[NET_DUP_BIT]) begin
            nxt_net_mode = NM_DUP;
        end else if (net_ctrl_ff[NET_TMO_BIT]) begin
            nxt_net_mode = NM_TMO;
        end else if (net_ctrl_ff[NET_CONN_BIT]) begin
            nxt_net_mode = NM_CONN;
        end else begin
            nxt_net_mode = NM_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mod_mode_ff <= MM_SELF;
            net_mode_ff <= NM_SELF;
            mod_ph_ff <= '0;
            net_ph_ff <= '0;
        end else begin
            mod_mode_ff <= nxt_mod_mode;
            net_mode_ff <= nxt_net_mode;
            mod_ph_ff <= (nxt_mod_mode != mod_mode_ff) ? '0
                       : phase_step(mod_ph_ff, BLINK_PERIOD_MS, ms_tick);
            net_ph_ff <= (nxt_net_mode != net_mode_ff) ? '0
                       : phase_step(net_ph_ff, BLINK_PERIOD_MS, ms_tick);
        end
    end

    // duo-colour outputs
    inl_duo_t mod_led_ff, net_led_ff;
    logic mod_lit, net_lit;
    assign mod_lit = (mod_ph_ff < BLINK_HALF_MS);
    assign net_lit = (net_ph_ff < BLINK_HALF_MS);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mod_led_ff <= DUO_OFF;
        end else begin
            case (mod_mode_ff)
                MM_SELF: mod_led_ff <= (st_ff == ST_MS_R) ? DUO_RED : DUO_GREEN;
                MM_UNREC: mod_led_ff <= DUO_RED;
                MM_RECOV: mod_led_ff <= mod_lit ? DUO_RED : DUO_OFF;
                MM_STBY: mod_led_ff <= mod_lit ? DUO_GREEN : DUO_OFF;
                MM_OK: mod_led_ff <= DUO_GREEN;
                default: mod_led_ff <= DUO_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            net_led_ff <= DUO_OFF;
        end else begin
            case (net_mode_ff)
                NM_SELF: begin
                    if (st_ff == ST_NS_G) begin
                        net_led_ff <= DUO_GREEN;
                    end else if (st_ff == ST_NS_R) begin
                        net_led_ff <= DUO_RED;
                    end else begin
                        net_led_ff <= DUO_OFF;
                    end
                end
                NM_OFF: net_led_ff <= DUO_OFF;
                NM_DUP: net_led_ff <= DUO_RED;
                NM_TMO: net_led_ff <= net_lit ? DUO_RED : DUO_OFF;
                NM_CONN: net_led_ff <= DUO_GREEN;
                NM_IDLE: net_led_ff <= net_lit ? DUO_GREEN : DUO_OFF;
                default: net_led_ff <= DUO_OFF;
            endcase
        end
    end

    assign module_health_indicator_o = mod_led_ff;
    assign network_health_indicator_o = net_led_ff;

    // link and traffic indicators
    logic [NUM_CH-1:0] link_led_ff, act_led_ff, act_run_ff, act_pend_ff;
    logic [MS_W-1:0] act_ph_ff [NUM_CH];
    logic [NUM_CH-1:0] frame_seen;
    assign frame_seen = frame_s2_ff & ~frame_s3_ff;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            link_led_ff <= '0;
        end else begin
            link_led_ff <= link_s2_ff;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            act_run_ff <= '0;
            act_pend_ff <= '0;
            act_led_ff <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                act_ph_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!act_run_ff[i]) begin
                    act_ph_ff[i] <= '0;
                    act_run_ff[i] <= act_pend_ff[i];
                    act_pend_ff[i] <= frame_seen[i];
                end else if (ms_tick && act_ph_ff[i] == FLICK_PERIOD_MS - 10'd1) begin
                    act_ph_ff[i] <= '0;
                    act_run_ff[i] <= act_pend_ff[i];
                    act_pend_ff[i] <= frame_seen[i];
                end else begin
                    act_ph_ff[i] <= phase_step(act_ph_ff[i], FLICK_PERIOD_MS, ms_tick);
                    act_pend_ff[i] <= act_pend_ff[i] | frame_seen[i];
                end
                act_led_ff[i] <= act_run_ff[i] && (act_ph_ff[i] < FLICK_HALF_MS);
            end
        end
    end

    assign link_indicator_o = link_led_ff;
    assign traffic_indicator_o = act_led_ff;
    assign led_stat = {22'h000000, act_led_ff, link_led_ff, net_led_ff, mod_led_ff,
                       (st_ff == ST_HOLD), (st_ff != ST_IDLE)};

    // checks
    AST_DUO_EXCL: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !(mod_led_ff.red && mod_led_ff.green) && !(net_led_ff.red && net_led_ff.green))
        else $error("duo indicator lit red and green");
    AST_OK_GREEN: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (mod_mode_ff == MM_OK) ##1 (mod_mode_ff == MM_OK) |-> mod_led_ff == DUO_GREEN)
        else $error("operational module indicator not green");
    AST_UNREC_RED: assert property (@(posedge core_clk_i) disable iff (reset_i)
        mod_ctrl_ff[MOD_UNREC_BIT] && !selftest |-> ##2 mod_led_ff == DUO_RED)
        else $error("unrecoverable fault not steady red");
    AST_NOIP_DARK: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !net_ctrl_ff[NET_IP_BIT] && !selftest ##1 !net_ctrl_ff[NET_IP_BIT] && !selftest
        |-> ##1 net_led_ff == DUO_OFF)
        else $error("network indicator lit without ip");
    AST_DUP_RED: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (net_mode_ff == NM_DUP) [*2] |-> net_led_ff == DUO_RED)
        else $error("duplicate ip not steady red");
    AST_BLINK_WRAP: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ms_tick && mod_ph_ff == BLINK_PERIOD_MS - 10'd1 && nxt_mod_mode == mod_mode_ff
        |=> mod_ph_ff == '0)
        else $error("blink period not 1000 ms");
    AST_MODE_RESTART: assert property (@(posedge core_clk_i) disable iff (reset_i)
        nxt_net_mode != net_mode_ff |=> net_ph_ff == '0)
        else $error("mode change did not restart phase");
    AST_ST_ORDER: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $changed(st_ff) && st_ff == ST_NS_G |-> $past(st_ff) == ST_MS_R)
        else $error("network self-test began before module test ended");
    AST_ST_HOLD_OFF: assert property (@(posedge core_clk_i) disable iff (reset_i)
        st_ff == ST_HOLD && net_mode_ff == NM_SELF ##1 st_ff == ST_HOLD
        |-> net_led_ff == DUO_OFF && mod_led_ff == DUO_GREEN)
        else $error("self-test hold pattern wrong");
    AST_LINK: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $rose(link_s2_ff[0]) |=> link_indicator_o[0])
        else $error("link indicator did not follow link");
    AST_ACT_IDLE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !act_run_ff[0] |=> !act_led_ff[0])
        else $error("traffic indicator lit without frames");
    AST_TICK_PULSE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ms_tick |=> !ms_tick [*2])
        else $error("ms tick not a single pulse");
endmodule : inl_status_led
`default_nettype wire

// >>> dv/inl_led_panel.sv
`timescale 1ns/10ps
`default_nettype none
module inl_led_panel
    import inl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // duo lamp drives
    input wire inl_pkg::inl_duo_t module_led_i,
    input wire inl_pkg::inl_duo_t network_led_i,
    // lamp faults seen
    output var int conflicts_o
);
    // a duo lamp lit in both colours at once
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conflicts_o <= 0;
        end else if (&module_led_i || &network_led_i) begin
            conflicts_o <= conflicts_o + 1;
        end
    end
endmodule : inl_led_panel
`default_nettype wire

// >>> dv/inl_status_led_bench.sv
`timescale 1ns/10ps
`default_nettype none
module inl_status_led_bench;
    import inl_pkg::*;
    localparam int TICK_C = 4;
    localparam int LIMIT = 60000;
    logic clk;
    logic reset;
    inl_apb_req_t req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic err;
    logic [NUM_CH-1:0] link = '0;
    logic [NUM_CH-1:0] frame = '0;
    logic [NUM_CH-1:0] link_led;
    logic [NUM_CH-1:0] traffic_led;
    inl_duo_t mod_led;
    inl_duo_t net_led;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int conflicts;
    int len;
    int seed_dummy;
    logic [3:0] m;
    logic [3:0] n;
    logic [3:0] cm [4] = '{4'h2, 4'h2, 4'he, 4'h2};
    logic [3:0] cn [4] = '{4'hd, 4'h6, 4'h7, 4'h3};
    logic [1:0] st_mod [5] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h1};
    logic [1:0] st_net [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    int st_at [6] = '{0, 500, 1500, 2500, 3500, 4500};

    inl_status_led #(.TICK_CYCLES(TICK_C)) uut (
        .core_clk_i(clk), .reset_i(reset), .apb_req_i(req), .pready_o(pready),
        .pslverr_o(pslverr), .prdata_o(prdata), .link_i(link), .frame_i(frame),
        .module_health_indicator_o(mod_led), .network_health_indicator_o(net_led),
        .link_indicator_o(link_led), .traffic_indicator_o(traffic_led));
    inl_led_panel panel (.clk_i(clk), .reset_i(reset), .module_led_i(mod_led),
        .network_led_i(net_led), .conflicts_o(conflicts));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask : check_word

    task automatic check_duo(input string what, input inl_duo_t e, input inl_duo_t s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, e, s);
        end
    endtask : check_duo

    task automatic check_len(input string what, input int e, input int s);
        checks_done++;
        if (s < e - TICK_C || s > e + TICK_C) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", what, e, s);
        end
    endtask : check_len

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '{1'b0, 1'b0, w, a, d};
    endtask : apb

    function automatic logic [1:0] view(input int sel);
        case (sel)
            0: return mod_led;
            1: return net_led;
            2: return {1'b0, traffic_led[0]};
            default: return {1'b0, traffic_led[1]};
        endcase
    endfunction : view

    // wait for a lamp to show v, then count how long it holds
    task automatic hold_len(input int sel, input logic [1:0] v);
        int k;
        k = 0;
        while (view(sel) !== v && k < 3000) begin
            @(posedge clk);
            k++;
        end
        len = 0;
        while (view(sel) === v && len < 3000) begin
            @(posedge clk);
            len++;
        end
    endtask : hold_len

    function automatic inl_duo_t exp_mod(input logic [3:0] c, input logic lit);
        if (c[MOD_UNREC_BIT]) return '{1'b1, 1'b0};
        if (c[MOD_RECOV_BIT]) return '{lit, 1'b0};
        if (!c[MOD_CONFIGURED_BIT]) return '{1'b0, lit};
        return '{1'b0, 1'b1};
    endfunction : exp_mod

    function automatic inl_duo_t exp_net(input logic [3:0] c, input logic lit);
        if (!c[NET_IP_BIT]) return '{1'b0, 1'b0};
        if (c[NET_DUP_BIT]) return '{1'b1, 1'b0};
        if (c[NET_TMO_BIT]) return '{lit, 1'b0};
        if (c[NET_CONN_BIT]) return '{1'b0, 1'b1};
        return '{1'b0, lit};
    endfunction : exp_net

    // pass through self-test so both modes change, then sample lit and dark
    task automatic run_case(input logic [3:0] mc, input logic [3:0] nc);
        apb(1'b1, MOD_CTRL_OFS, 32'h1);
        apb(1'b1, NET_CTRL_OFS, 32'h0);
        apb(1'b1, MOD_CTRL_OFS, {28'h0, mc});
        apb(1'b1, NET_CTRL_OFS, {28'h0, nc});
        repeat (250 * TICK_C) @(posedge clk);
        check_duo("mod lit phase", exp_mod(mc, 1'b1), mod_led);
        check_duo("net lit phase", exp_net(nc, 1'b1), net_led);
        repeat (500 * TICK_C) @(posedge clk);
        check_duo("mod dark phase", exp_mod(mc, 1'b0), mod_led);
        check_duo("net dark phase", exp_net(nc, 1'b0), net_led);
    endtask : run_case

    initial begin
        reset = 1'b1;
        req = '0;
        seed_dummy = $urandom(32'hff10);
        repeat (10) @(posedge clk);
        check_duo("mod in reset", 2'h0, mod_led);
        reset <= 1'b0;
        apb(1'b1, MOD_CTRL_OFS, 32'hffff_fff2);
        apb(1'b1, NET_CTRL_OFS, 32'h3);
        apb(1'b0, MOD_CTRL_OFS, 32'h0);
        check_word("mod ctrl readback", 32'h2, rd);
        apb(1'b1, LED_STAT_OFS, 32'hffff_ffff);
        check_word("status write error", 32'h0, {31'h0, err});
        apb(1'b0, LED_STAT_OFS, 32'h0);
        check_word("status lamps", 32'h14, rd & 32'h3c);
        apb(1'b0, 12'h00c, 32'h0);
        check_word("unmapped error", 32'h1, {31'h0, err});
        check_word("unmapped data", 32'h0, rd);
        $display("test registers done");
        apb(1'b1, NET_CTRL_OFS, 32'h0);
        apb(1'b1, MOD_CTRL_OFS, 32'h1);
        for (int k = 0; k < 5; k++) begin
            repeat (st_at[k + 1] - st_at[k]) @(posedge clk);
            check_duo("selftest mod", st_mod[k], mod_led);
            check_duo("selftest net", st_net[k], net_led);
        end
        $display("test selftest done");
        apb(1'b1, MOD_CTRL_OFS, 32'h0);
        hold_len(0, 2'h0);
        check_len("flash dark length", 500 * TICK_C, len);
        hold_len(0, 2'h1);
        check_len("flash lit length", 500 * TICK_C, len);
        $display("test flash timing done");
        for (int i = 0; i < 10; i++) begin
            m = (i < 4) ? cm[i] : 4'($urandom) & 4'he;
            n = (i < 4) ? cn[i] : 4'($urandom);
            run_case(m, n);
        end
        $display("test mode table done");
        repeat (3) begin
            link <= 2'($urandom);
            repeat (6) @(posedge clk);
            check_word("link lamps", {30'h0, link}, {30'h0, link_led});
        end
        frame[0] <= 1'b1;
        repeat (2) @(posedge clk);
        frame[0] <= 1'b0;
        hold_len(2, 2'h1);
        check_len("single frame lit", 50 * TICK_C, len);
        repeat (400) @(posedge clk);
        check_word("traffic idle", 32'h0, {30'h0, traffic_led});
        fork
            repeat (60) begin
                frame[1] <= 1'b1;
                repeat (2) @(posedge clk);
                frame[1] <= 1'b0;
                repeat (18) @(posedge clk);
            end
            begin
                hold_len(3, 2'h1);
                check_len("busy lit", 50 * TICK_C, len);
                hold_len(3, 2'h0);
                check_len("busy dark", 50 * TICK_C, len);
            end
        join
        $display("test traffic done");
        check_word("duo conflicts", 32'h0, 32'(conflicts));
        complete_run();
    end
endmodule : inl_status_led_bench
`default_nettype wire
